// ### tb/blc_host.sv
/* Host model taking pixel beats from blc_top into a queue.
   Assumes the bench tells it when the 8-bit bus mode is on. */
`timescale 1ns/1ps
module blc_host
  import blc_pkg::*;
(
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic            eight_bit,
  input wire blc_pix_out_type pix
);
  logic [15:0] got[$];

  // Never stalls; chroma bus is dropped in 8-bit mode, as a real host would
  always @(posedge clk) begin
    if (rst_n && pix.valid === 1'b1) begin
      got.push_back({pix.y, eight_bit ? 8'h00 : pix.c});
    end
  end
endmodule

// ### tb/blc_monitor.sv
/* Port checker for blc_top: bus answer, read data hold, beat timing.
   Assumes it is bound into blc_top and that one clock drives everything. */
`timescale 1ns/1ps
module blc_monitor
  import blc_pkg::*;
(
  input wire logic            SYS_CLK,
  input wire logic            RST_N,
  input wire logic            HSEL,
  input wire logic [1:0]      HTRANS,
  input wire logic            HWRITE,
  input wire logic            HREADY,
  input wire logic [31:0]     HRDATA,
  input wire logic            HREADYOUT,
  input wire logic            HRESP,
  input wire blc_pix_in_type  PIX_IN,
  input wire logic            PIX_READY,
  input wire blc_pix_out_type PIX_OUT
);
  // One domain, so clock and disable are declared once
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // Active pixel taken, and the two beats that a wide pixel gives
  sequence s_act;
    PIX_IN.valid && PIX_READY && !PIX_IN.shielded;
  endsequence
  sequence s_pair;
    PIX_OUT.valid && !PIX_READY ##1 PIX_OUT.valid && PIX_READY;
  endsequence

  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready or not okay");
  a_rdata_top: assert property (HRDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_rdata_hold: assert property (!(HSEL && HTRANS[1] && HREADY && !HWRITE) |=> $stable(HRDATA))
    else $error("read data moved without a read");
  a_reset_clean: assert property ($rose(RST_N) |-> PIX_OUT == '0 && HRDATA == 32'h0 && PIX_READY)
    else $error("outputs not clean after reset");
  a_shield_quiet: assert property (PIX_IN.valid && PIX_READY && PIX_IN.shielded |=> !PIX_OUT.valid)
    else $error("shielded pixel produced a beat");
  a_active_beat: assert property (s_act |=> PIX_OUT.valid)
    else $error("active pixel gave no beat");
  a_beat_pair: assert property ($fell(PIX_READY) |-> s_pair)
    else $error("two-beat pixel not sent as a pair");
  a_ready_short: assert property (!PIX_READY |=> PIX_READY)
    else $error("ready low longer than one cycle");
  a_beat_cause: assert property (PIX_OUT.valid |->
      ($past(PIX_IN.valid) && $past(PIX_READY) && !$past(PIX_IN.shielded)) || !$past(PIX_READY))
    else $error("beat without a pixel behind it");
endmodule

// ### tb/test_black_level_and_output_format_ctrl.sv
/* Self-checking bench for blc_top: AHB-Lite register tasks, pixel source,
   host model and a reference queue. Assumes blc_pkg and the monitor. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_black_level_and_output_format_ctrl
  import blc_pkg::*;
;
  logic            clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, eight_q = 1'b0;
  logic [1:0]      htrans = 2'h0;
  logic [2:0]      hsize = 3'h2;
  logic [31:0]     haddr = 32'h0, hwdata = 32'h0, seed = 32'hae7e;
  wire  [31:0]     hrdata;
  wire             hready, hresp, pix_ready;
  blc_pix_in_type  pix = '0;
  blc_pix_out_type pix_out;
  logic [15:0]     exp_q[$], gv, ev;
  logic [7:0]      rd, w;
  logic [9:0]      s, r, g, b;
  int              mismatches = 0, n_tests = 0;
  logic [7:0] idx_t[11] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2f, 8'h30, 8'h31, 8'h28};
  logic [7:0] rst_t[11] = '{8'h7f, 8'h7f, 8'h7f, 8'h00, 8'h00, 8'h00, 8'hff, 8'h02, 8'h0f, 8'h39, 8'h00};
  logic [7:0] msk_t[11] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h03, 8'h0e, 8'hfb, 8'h00};
  logic [7:0] fmt_t[9] = '{8'h09, 8'h19, 8'h29, 8'h39, 8'h01, 8'h31, 8'h02, 8'h22, 8'h02};

  blc_top uut (
    .SYS_CLK   (clk),
    .RST_N     (rst_n),
    .HSEL      (hsel),
    .HADDR     (haddr),
    .HTRANS    (htrans),
    .HWRITE    (hwrite),
    .HSIZE     (hsize),
    .HWDATA    (hwdata),
    .HREADY    (hready),
    .HRDATA    (hrdata),
    .HREADYOUT (hready),
    .HRESP     (hresp),
    .PIX_IN    (pix),
    .PIX_READY (pix_ready),
    .PIX_OUT   (pix_out)
  );
  blc_host host (.clk(clk), .rst_n(rst_n), .eight_bit(eight_q), .pix(pix_out));

  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Wait for hready at a rising edge; only the watchdog ends a hang
  task wait_rdy();
    @(posedge clk);
    while (hready !== 1'b1) begin
      @(posedge clk);
    end
  endtask

  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'h0};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata[7:0];
  endtask

  // Pixel held until ready is seen; next call changes it at the accepting edge
  task send(input logic fe, sh, input logic [1:0] col, input logic [9:0] sv, rv = 10'h0, gv2 = 10'h0,
            bv = 10'h0);
    @(posedge clk);
    pix <= '{1'b1, fe, sh, col, sv, rv, gv2, bv};
    @(negedge clk);
    while (pix_ready !== 1'b1) begin
      @(negedge clk);
    end
  endtask

  task check_out();
    @(posedge clk);
    pix.valid <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(host.got.size(), exp_q.size())
    while (exp_q.size() > 0 && host.got.size() > 0) begin
      gv = host.got.pop_front();
      ev = exp_q.pop_front();
      `CHK(gv, ev)
    end
    exp_q.delete();
    host.got.delete();
  endtask

  // Beats a YCbCr or RGB pixel should give; even pixels carry the first chroma
  task exp_yc(input logic [7:0] f, input int odd, input logic [7:0] y, cb, cr);
    logic [7:0] c1, c2;
    c1 = f[5] ? cb : cr;
    c2 = f[5] ? cr : cb;
    if (f[3] && f[4]) begin
      exp_q.push_back({y, 8'h00});
      exp_q.push_back({odd ? c2 : c1, 8'h00});
    end else if (f[3]) begin
      exp_q.push_back({odd ? c2 : c1, 8'h00});
      exp_q.push_back({y, 8'h00});
    end else if (f[0] || !f[1]) begin
      exp_q.push_back({y, odd ? c2 : c1});
    end else begin
      exp_q.push_back({y, c1});
      exp_q.push_back({c2, 8'h00});
    end
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  initial begin
    repeat (8000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, then random writes; reserved and read-only bits hold
    for (int i = 0; i < 11; i++) begin
      bus(1'b0, idx_t[i], 8'h00);
      `CHK(rd, rst_t[i])
      w = 8'(rnd());
      bus(1'b1, idx_t[i], w);
      bus(1'b0, idx_t[i], 8'h00);
      `CHK(rd, (w & msk_t[i]) | (i == 8 ? 8'h01 : 8'h00))
    end
    // Bayer output, full and with low bits dropped
    bus(1'b1, 8'h2f, 8'h01);
    bus(1'b1, 8'h30, 8'h00);
    eight_q <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 8'h31, k ? 8'h40 : 8'h00);
      for (int j = 0; j < 6; j++) begin
        s = 10'(rnd());
        send(j == 3, j == 3, 2'd1, s);
        if (j != 3) exp_q.push_back({s[9:2], k ? 8'h00 : {6'h0, s[1:0]}});
      end
      check_out();
    end
    // One frame: red subtract 5, some red over threshold, green one short
    bus(1'b1, 8'h21, 8'h85);
    bus(1'b1, 8'h27, 8'h10);
    for (int j = 0; j < 72; j++) begin
      send(1'b0, 1'b1, 2'd0, (j % 9 == 8) ? 10'h3ff : 10'd25);
      if (j < 63) send(1'b0, 1'b1, 2'd1, 10'd25);
    end
    send(1'b1, 1'b1, 2'd2, 10'h0);
    check_out();
    bus(1'b0, 8'h24, 8'h00);
    `CHK(rd, 8'h94)
    bus(1'b0, 8'h25, 8'h00);
    `CHK(rd, 8'h00)
    // Active red offset now subtracts 20 from active red samples
    bus(1'b1, 8'h31, 8'h00);
    send(1'b0, 1'b0, 2'd0, 10'd101);
    exp_q.push_back({8'h14, 8'h01});
    check_out();
    // YCbCr orders and widths, matrix off; last case repeats the Bayer value
    bus(1'b1, 8'h2f, 8'h02);
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, 8'h30, i == 8 ? 8'h00 : 8'h04);
      bus(1'b1, 8'h31, fmt_t[i]);
      eight_q <= fmt_t[i][3];
      send(1'b1, 1'b1, 2'd2, 10'h0);
      for (int j = 0; j < 3; j++) begin
        r = 10'(rnd());
        g = 10'(rnd());
        b = 10'(rnd());
        s = 10'(rnd());
        send(1'b0, 1'b0, 2'd1, s, r, g, b);
        if (i == 8) exp_yc(fmt_t[i], j % 2, s[9:2], s[9:2], s[9:2]);
        else exp_yc(fmt_t[i], j % 2, g[9:2], b[9:2], r[9:2]);
      end
      check_out();
    end
    // Gamma lifts a dark level, and Bayer and video paths share one curve
    bus(1'b1, 8'h30, 8'h02);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 8'h2f, k ? 8'h02 : 8'h01);
      bus(1'b1, 8'h31, k ? 8'h01 : 8'h80);
      send(1'b0, 1'b0, 2'd1, 10'd40);
      @(posedge clk);
      pix.valid <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(host.got.size(), 1)
      ev = host.got.pop_front();
      if (k) `CHK(ev[15:8], gv[15:8])
      else `CHK(ev[15:8] > 8'd10, 1'b1)
      gv = ev;
      host.got.delete();
    end
    // Matrix on: a blue then a green pixel, weights of the conversion equation
    bus(1'b1, 8'h30, 8'h0c);
    bus(1'b1, 8'h31, 8'h01);
    send(1'b1, 1'b1, 2'd2, 10'h0);
    send(1'b0, 1'b0, 2'd1, 10'h0, 10'h0, 10'h0, 10'h3fc);
    exp_q.push_back({8'h1c, 8'h6b});
    send(1'b0, 1'b0, 2'd1, 10'h0, 10'h0, 10'h3fc, 10'h0);
    exp_q.push_back({8'h95, 8'h29});
    check_out();
    // Second reset in mid-run restores the format register
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 8'h31, 8'h00);
    `CHK(rd, 8'h39)
    stop_test();
  end
endmodule

bind blc_top blc_monitor u_mon (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PIX_IN(PIX_IN),
  .PIX_READY(PIX_READY), .PIX_OUT(PIX_OUT));

// ### verilog/blc_cfg.svh
/*
  Register indices, field positions, reset values and fixed arithmetic
  constants of the black level and output format block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef BLC_CFG_SVH
`define BLC_CFG_SVH

// Register indices; byte address is index times four
`define BLC_IDX_SH_RED     8'h21
`define BLC_IDX_SH_GREEN   8'h22
`define BLC_IDX_SH_BLUE    8'h23
`define BLC_IDX_ACT_RED    8'h24
`define BLC_IDX_ACT_GREEN  8'h25
`define BLC_IDX_ACT_BLUE   8'h26
`define BLC_IDX_THRESH     8'h27
`define BLC_IDX_MODE       8'h2f
`define BLC_IDX_STAGE_EN   8'h30
`define BLC_IDX_OUT_FMT    8'h31

// Reset values
`define BLC_RST_SH_OFFSET  8'h7f
`define BLC_RST_ACT_OFFSET 8'h00
`define BLC_RST_THRESH     8'hff
`define BLC_RST_MODE       8'h02
`define BLC_RST_STAGE_EN   8'h0f
`define BLC_RST_OUT_FMT    8'h39

// Offset register fields
`define BLC_OFS_SIGN       7

// Stage enable fields and the mask of writable bits
`define BLC_EN_MATRIX      3
`define BLC_EN_INTERP      2
`define BLC_EN_GAMMA       1
`define BLC_EN_WMASK       8'h0e

// Output format fields and writable mask
`define BLC_FMT_GAMMA_BAY  7
`define BLC_FMT_BAY8       6
`define BLC_FMT_CB_FIRST   5
`define BLC_FMT_Y_FIRST    4
`define BLC_FMT_EIGHT      3
`define BLC_FMT_444        1
`define BLC_FMT_422        0
`define BLC_FMT_WMASK      8'hfb

// Mode register fields
`define BLC_MODE_BAYER     0
`define BLC_MODE_INTERP3   1

// Black level averaging: shielded pixels per colour per frame
`define BLC_AVG_SHIFT      6
`define BLC_AVG_COUNT      7'd64

// Colour space conversion weights and chroma bias
`define BLC_CY_R           18'sd77
`define BLC_CY_G           18'sd150
`define BLC_CY_B           18'sd29
`define BLC_CB_R           -18'sd44
`define BLC_CB_G           -18'sd87
`define BLC_CB_B           18'sd131
`define BLC_CR_R           18'sd131
`define BLC_CR_G           -18'sd110
`define BLC_CR_B           -18'sd21
`define BLC_C_BIAS         18'sd32768

`endif

// ### verilog/blc_pkg.sv
/*
  Types shared by the black level and output format block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package blc_pkg;

  // Incoming pixel from the sensor readout, same clock
  typedef struct packed {
    logic       valid;
    logic       frame_end;
    logic       shielded;
    logic [1:0] colour;
    logic [9:0] sample;
    logic [9:0] r;
    logic [9:0] g;
    logic [9:0] b;
  } blc_pix_in_type;

  // One beat toward the host
  typedef struct packed {
    logic       valid;
    logic [7:0] y;
    logic [7:0] c;
  } blc_pix_out_type;

endpackage

// ### verilog/blc_top.sv
/*
  Black level compensation and output formatting with its registers,
  reached over AHB-Lite. Assumes a pixel source on SYS_CLK that holds
  a pixel until PIX_READY is seen, and a host that takes every beat.
*/
// Chosen here: the AHB-Lite interface to the registers.
// How it works
// - Shielded offset bit 7 picks subtract (1) or add (0).
// - Shielded offset bits 6:0 give magnitude; reset value 7fh.
// - Active offsets are read-only; only compensation logic writes them.
// - Active offset bit 7 picks subtract or add, bits 6:0 magnitude.
// - Shielded pixels above threshold are left out; threshold resets ffh.
// - Stage bit 3 enables colour matrix, else RGB passes unconverted.
// - In 3x3 mode stage bit 2 picks interpolated RGB or repeated Bayer.
// - Stage bit 1 enables ten-segment piecewise-linear gamma.
// - Format bit 7 sends gamma-corrected Bayer in Bayer mode.
// - Format bit 6 drops two LSBs of Bayer, giving eight bits.
// - Format bit 5 places Cb ahead of Cr in both bus widths.
// - Format bit 4 places Y ahead of chroma in 8-bit mode only.
// - Format bit 3 drives image data only on the luma bus, except in Bayer mode.
// - 16-bit mode with format bit 1 set and bit 0 clear gives 24 bits per pixel.
// - Format bit 0 selects YCbCr 4:2:2; register resets to 39h.
`timescale 1ns/1ps
`include "blc_cfg.svh"

module blc_top
  import blc_pkg::*;
(
  input  wire logic            SYS_CLK,
  input  wire logic            RST_N,
  input  wire logic            HSEL,
  input  wire logic [31:0]     HADDR,
  input  wire logic [1:0]      HTRANS,
  input  wire logic            HWRITE,
  input  wire logic [2:0]      HSIZE,
  input  wire logic [31:0]     HWDATA,
  input  wire logic            HREADY,
  output logic      [31:0]     HRDATA,
  output logic                 HREADYOUT,
  output logic                 HRESP,
  input  wire blc_pix_in_type  PIX_IN,
  output logic                 PIX_READY,
  output blc_pix_out_type      PIX_OUT
);

  // Ten-segment gamma curve: start points, start levels, slopes in 1/16
  // Slopes fall with level, so dark tones are lifted the most
  localparam logic [9:0] G_X [10] = '{10'd0, 10'd16, 10'd32, 10'd64, 10'd128,
                                      10'd192, 10'd256, 10'd384, 10'd512, 10'd768};
  localparam logic [9:0] G_Y [10] = '{10'd0, 10'd96, 10'd160, 10'd240, 10'd352,
                                      10'd440, 10'd512, 10'd640, 10'd736, 10'd880};
  localparam logic [6:0] G_S [10] = '{7'd96, 7'd64, 7'd40, 7'd28, 7'd22,
                                      7'd18, 7'd16, 7'd12, 7'd9, 7'd9};

  // Register file, black averager and output beat state
  logic [7:0]  sh_ofs_q [3];
  logic [7:0]  act_ofs_q [3];
  logic [7:0]  thresh_q;
  logic [7:0]  mode_q;
  logic [7:0]  stage_en_q;
  logic [7:0]  out_fmt_q;
  logic        wr_pend_q;
  logic [7:0]  wr_idx_q;
  logic        addr_ok;
  logic [7:0]  addr_idx;
  logic [7:0]  rd_val;
  logic [15:0] acc_q [3];
  logic [6:0]  cnt_q [3];
  logic        beat_q;
  logic        odd_q;
  blc_pix_out_type hold_q;
  blc_pix_out_type out_q;

  // Saturating sign-magnitude offset on a 10-bit sample
  // Clamping, not wrapping, keeps a dark pixel from turning white
  function automatic logic [9:0] apply_ofs(input logic [9:0] s, input logic [7:0] o);
    logic [10:0] t;
    t = 11'h000;
    if (o[`BLC_OFS_SIGN]) begin
      t = {1'b0, s} - {4'h0, o[6:0]};
      apply_ofs = t[10] ? 10'h000 : t[9:0];
    end else begin
      t = {1'b0, s} + {4'h0, o[6:0]};
      apply_ofs = t[10] ? 10'h3ff : t[9:0];
    end
  endfunction

  // Piecewise-linear gamma, saturating at full scale
  // The last start point not above x picks the segment
  function automatic logic [9:0] gamma(input logic [9:0] x);
    logic [3:0]  k;
    logic [16:0] p;
    logic [11:0] y;
    k = 4'd0;
    p = 17'h00000;
    y = 12'h000;
    for (int i = 1; i < 10; i++) begin
      if (x >= G_X[i]) begin
        k = 4'(i);
      end
    end
    p = 17'(x - G_X[k]) * 17'(G_S[k]);
    y = 12'(G_Y[k]) + 12'(p[16:4]);
    gamma = (y > 12'h3ff) ? 10'h3ff : y[9:0];
  endfunction

  // Clamp a scaled matrix sum to one byte
  function automatic logic [7:0] clamp8(input logic signed [17:0] v);
    if (v < 0) begin
      clamp8 = 8'h00;
    end else if (v > 18'sd65535) begin
      clamp8 = 8'hff;
    end else begin
      clamp8 = v[15:8];
    end
  endfunction

  // Zero-wait slave; every transfer answers OKAY
  // HSIZE is not decoded; only whole-word transfers are expected
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign addr_idx  = HADDR[9:2];
  assign addr_ok   = HSEL & HTRANS[1] & HREADY & (HADDR[31:10] == 22'h000000);

  // Read mux; unmapped indices and upper bits read zero
  always_comb begin
    if (addr_idx == `BLC_IDX_SH_RED) begin
      rd_val = sh_ofs_q[0];
    end else if (addr_idx == `BLC_IDX_SH_GREEN) begin
      rd_val = sh_ofs_q[1];
    end else if (addr_idx == `BLC_IDX_SH_BLUE) begin
      rd_val = sh_ofs_q[2];
    end else if (addr_idx == `BLC_IDX_ACT_RED) begin
      rd_val = act_ofs_q[0];
    end else if (addr_idx == `BLC_IDX_ACT_GREEN) begin
      rd_val = act_ofs_q[1];
    end else if (addr_idx == `BLC_IDX_ACT_BLUE) begin
      rd_val = act_ofs_q[2];
    end else if (addr_idx == `BLC_IDX_THRESH) begin
      rd_val = thresh_q;
    end else if (addr_idx == `BLC_IDX_MODE) begin
      rd_val = mode_q;
    end else if (addr_idx == `BLC_IDX_STAGE_EN) begin
      rd_val = stage_en_q;
    end else if (addr_idx == `BLC_IDX_OUT_FMT) begin
      rd_val = out_fmt_q;
    end else begin
      rd_val = 8'h00;
    end
  end

  // Read data captured in the address phase, shown in the data phase
  // Loaded only on a taken read, so the word stands through idle cycles
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      HRDATA <= 32'h00000000;
    end else if (addr_ok && !HWRITE) begin
      HRDATA <= {24'h000000, rd_val};
    end
  end

  // Address phase of a write remembered for its data phase
  // Held across wait states even though this slave inserts none
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else if (HREADY) begin
      wr_pend_q <= addr_ok & HWRITE;
      wr_idx_q  <= addr_idx;
    end
  end

  // Software-writable registers; active offsets have no write path
  // A read right behind a write to the same word still sees the old value
  // Only the low byte of HWDATA is kept; registers are one byte wide
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sh_ofs_q[0] <= `BLC_RST_SH_OFFSET;
      sh_ofs_q[1] <= `BLC_RST_SH_OFFSET;
      sh_ofs_q[2] <= `BLC_RST_SH_OFFSET;
      thresh_q    <= `BLC_RST_THRESH;
      mode_q      <= `BLC_RST_MODE;
      stage_en_q  <= `BLC_RST_STAGE_EN;
      out_fmt_q   <= `BLC_RST_OUT_FMT;
    end else if (wr_pend_q) begin
      if (wr_idx_q == `BLC_IDX_SH_RED) begin
        sh_ofs_q[0] <= HWDATA[7:0];
      end else if (wr_idx_q == `BLC_IDX_SH_GREEN) begin
        sh_ofs_q[1] <= HWDATA[7:0];
      end else if (wr_idx_q == `BLC_IDX_SH_BLUE) begin
        sh_ofs_q[2] <= HWDATA[7:0];
      end else if (wr_idx_q == `BLC_IDX_THRESH) begin
        thresh_q <= HWDATA[7:0];
      end else if (wr_idx_q == `BLC_IDX_MODE) begin
        mode_q <= HWDATA[7:0] & 8'h03;
      end else if (wr_idx_q == `BLC_IDX_STAGE_EN) begin
        stage_en_q <= (HWDATA[7:0] & `BLC_EN_WMASK) | (`BLC_RST_STAGE_EN & ~`BLC_EN_WMASK);
      end else if (wr_idx_q == `BLC_IDX_OUT_FMT) begin
        out_fmt_q <= (HWDATA[7:0] & `BLC_FMT_WMASK) | (`BLC_RST_OUT_FMT & ~`BLC_FMT_WMASK);
      end
    end
  end

  // Pixel acceptance: a two-beat pixel blocks the next one
  logic        accept;
  logic        frame_done;
  logic        act_take;
  logic [9:0]  sh_corr;
  logic [9:0]  act_corr;
  logic [1:0]  col;
  assign PIX_READY = ~beat_q;
  assign accept    = PIX_IN.valid & ~beat_q;
  // Frame end counts only on a taken pixel, so a held one acts once
  assign frame_done = accept & PIX_IN.frame_end;
  // Shielded pixels only feed the averager and never reach the host
  assign act_take   = accept & ~PIX_IN.shielded;
  assign col       = (PIX_IN.colour > 2'd2) ? 2'd2 : PIX_IN.colour;
  assign sh_corr   = apply_ofs(PIX_IN.sample, sh_ofs_q[col]);
  assign act_corr  = apply_ofs(PIX_IN.sample, act_ofs_q[col]);

  // Per-colour black averaging over the frame's shielded pixels
  generate
    for (genvar c = 0; c < 3; c++) begin : g_blc
      logic take;
      logic [15:0] mean;
      // Pixels above the threshold would drag black level upward
      assign take = accept & PIX_IN.shielded & (col == 2'(c)) &
                    (sh_corr[9:2] <= thresh_q) & (cnt_q[c] != `BLC_AVG_COUNT);
      // Sixty-four ten-bit samples fit in sixteen bits
      assign mean = acc_q[c] >> `BLC_AVG_SHIFT;
      always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
          acc_q[c]     <= 16'h0000;
          cnt_q[c]     <= 7'd0;
          act_ofs_q[c] <= `BLC_RST_ACT_OFFSET;
        end else if (frame_done) begin
          // Too few clean pixels keeps the previous offset
          if (cnt_q[c] == `BLC_AVG_COUNT) begin
            act_ofs_q[c] <= {1'b1, (mean > 16'd127) ? 7'h7f : mean[6:0]};
          end
          acc_q[c] <= 16'h0000;
          cnt_q[c] <= 7'd0;
        end else if (take) begin
          acc_q[c] <= acc_q[c] + {6'h00, sh_corr};
          cnt_q[c] <= cnt_q[c] + 7'd1;
        end
      end
    end
  endgenerate

  // Colour path: interpolation choice, gamma, matrix
  // Gamma works on ten bits before the matrix drops to eight
  logic [9:0] r_i, g_i, b_i, r_g, g_g, b_g, bay;
  logic [7:0] y8, cb8, cr8;
  logic signed [17:0] r_s, g_s, b_s;
  always_comb begin
    if (mode_q[`BLC_MODE_INTERP3] && stage_en_q[`BLC_EN_INTERP]) begin
      r_i = PIX_IN.r;
      g_i = PIX_IN.g;
      b_i = PIX_IN.b;
    end else begin
      r_i = act_corr;
      g_i = act_corr;
      b_i = act_corr;
    end
    r_g = stage_en_q[`BLC_EN_GAMMA] ? gamma(r_i) : r_i;
    g_g = stage_en_q[`BLC_EN_GAMMA] ? gamma(g_i) : g_i;
    b_g = stage_en_q[`BLC_EN_GAMMA] ? gamma(b_i) : b_i;
    bay = out_fmt_q[`BLC_FMT_GAMMA_BAY] ? gamma(act_corr) : act_corr;
    r_s = 18'(r_g[9:2]);
    g_s = 18'(g_g[9:2]);
    b_s = 18'(b_g[9:2]);
    // Weights are scaled by 256; the bias moves chroma to unsigned
    if (stage_en_q[`BLC_EN_MATRIX]) begin
      y8  = clamp8(`BLC_CY_R * r_s + `BLC_CY_G * g_s + `BLC_CY_B * b_s);
      cb8 = clamp8(`BLC_CB_R * r_s + `BLC_CB_G * g_s + `BLC_CB_B * b_s + `BLC_C_BIAS);
      cr8 = clamp8(`BLC_CR_R * r_s + `BLC_CR_G * g_s + `BLC_CR_B * b_s + `BLC_C_BIAS);
    end else begin
      // Unconverted RGB rides in the Y, Cb, Cr slots as G, B, R
      y8  = g_g[9:2];
      cb8 = b_g[9:2];
      cr8 = r_g[9:2];
    end
  end

  // Formatter: first beat now, optional second beat held
  logic [7:0] c_first, c_second, c_422;
  blc_pix_out_type beat_a, beat_b;
  logic two;
  always_comb begin
    c_first  = out_fmt_q[`BLC_FMT_CB_FIRST] ? cb8 : cr8;
    c_second = out_fmt_q[`BLC_FMT_CB_FIRST] ? cr8 : cb8;
    c_422    = odd_q ? c_second : c_first;
    beat_a   = '{valid: 1'b1, y: y8, c: c_422};
    beat_b   = '{valid: 1'b1, y: 8'h00, c: 8'h00};
    two      = 1'b0;
    // With both 4:2:2 and 4:4:4 set, 4:2:2 wins
    if (mode_q[`BLC_MODE_BAYER]) begin
      // Ten-bit Bayer splits its two LSBs onto the chroma bus
      beat_a.y = bay[9:2];
      beat_a.c = out_fmt_q[`BLC_FMT_BAY8] ? 8'h00 : {6'h00, bay[1:0]};
    end else if (out_fmt_q[`BLC_FMT_EIGHT]) begin
      // Chroma bus parked at zero; host discards it
      two      = 1'b1;
      beat_a.c = 8'h00;
      beat_a.y = out_fmt_q[`BLC_FMT_Y_FIRST] ? y8 : c_422;
      beat_b.y = out_fmt_q[`BLC_FMT_Y_FIRST] ? c_422 : y8;
    end else if (out_fmt_q[`BLC_FMT_444] && !out_fmt_q[`BLC_FMT_422]) begin
      two      = 1'b1;
      beat_a.c = c_first;
      beat_b.y = c_second;
    end
  end

  // Output beats and chroma phase; 4:2:2 alternates per active pixel
  // A two-beat pixel stalls the source one cycle; no buffer is kept
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      out_q  <= '{valid: 1'b0, y: 8'h00, c: 8'h00};
      hold_q <= '{valid: 1'b0, y: 8'h00, c: 8'h00};
      beat_q <= 1'b0;
      odd_q  <= 1'b0;
    end else if (beat_q) begin
      out_q  <= hold_q;
      beat_q <= 1'b0;
    end else if (act_take) begin
      out_q  <= beat_a;
      hold_q <= beat_b;
      beat_q <= two;
      odd_q  <= PIX_IN.frame_end ? 1'b0 : ~odd_q;
    end else begin
      out_q.valid <= 1'b0;
      if (frame_done) begin
        odd_q <= 1'b0;
      end
    end
  end

  assign PIX_OUT = out_q;

endmodule
